// *** hw/llmi_defs.vh ***
// constants for the lock-loss monitor and status interrupt block
// assumes a byte-wide register port at the device register offsets
`ifndef LLMI_DEFS_VH
`define LLMI_DEFS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define LLMI_ADDR_SIGNAL_LOSS_LIVE 16'h000d
`define LLMI_ADDR_LOCK_LIVE 16'h000e
`define LLMI_ADDR_SIGNAL_LOSS_STICKY 16'h0012
`define LLMI_ADDR_LOCK_STICKY 16'h0013
`define LLMI_ADDR_SIGNAL_LOSS_MASK 16'h0018
`define LLMI_ADDR_LOCK_MASK 16'h0019
`define LLMI_ADDR_ASSERT_THR 16'h009e
`define LLMI_ADDR_DEASSERT_THR 16'h00a0
`define LLMI_ADDR_TIMER_EN 16'h00a2
`define LLMI_ADDR_DELAY_B0 16'h00a8
`define LLMI_ADDR_DELAY_B1 16'h00a9
`define LLMI_ADDR_DELAY_B2 16'h00aa
`define LLMI_ADDR_DELAY_B3 16'h00ab
`define LLMI_ADDR_DELAY_B4 16'h00ac

// ****************************************************************
// field positions
// ****************************************************************
`define LLMI_LOCK_BIT 1
`define LLMI_TIMER_EN_BIT 1
`define LLMI_THR_MSB 7
`define LLMI_THR_LSB 4
`define LLMI_DELAY_TOP_BITS 3

// ****************************************************************
// reset values
// ****************************************************************
`define LLMI_ASSERT_THR_RESET 4'h0
`define LLMI_DEASSERT_THR_RESET 4'h2
`define LLMI_TIMER_EN_RESET 1'h0
`define LLMI_DELAY_RESET 35'h000000000
`define LLMI_SIGNAL_LOSS_MASK_RESET 2'h3
`define LLMI_LOCK_MASK_RESET 1'h1

// ****************************************************************
// threshold table, in tenths of a ppm
// ****************************************************************
`define LLMI_DIFF_WIDTH 20
`define LLMI_THR_CODE_MAX 4'ha

`endif

// *** hw/llmi_lock_monitor.v ***
// lock-loss monitor with status flags and an active-low interrupt pin
// assumes the frequency difference magnitude arrives from the phase
// detector front end, synchronous to clock, in tenths of a ppm
//
// Function
// - live lock-lost bit sets on loss of lock, clears when lock returns
// - loss detected from input versus feedback clock frequency difference
// - separate assert and deassert comparators give hysteresis
// - assert threshold picks one of eleven ppm steps, resets to 0.2 ppm
// - deassert threshold uses the same steps, resets to 2 ppm
// - optional 35-bit delay holds off clearing the lock-lost indication
// - timer enable zero bypasses the delay, one applies it
// - sticky lock-lost flag latches on assertion until software writes zero
// - lock-lost pin mirrors the live monitor state
// - interrupt pin reports any status indicator going high, not its return low
// - each indicator has a mask bit that keeps it off the interrupt
// - interrupt asserts when any flag is one with its mask zero
// - interrupt pin is active low
// - interrupt returns inactive once all unmasked flags are clear
// - writing zero clears a flag only while its live alarm is low
// - signal-loss sticky flags feed the interrupt through their own masks
`timescale 1ns/1ps
`include "llmi_defs.vh"

module llmi_lock_monitor
(
  // clock and reset
  input wire clock,
  input wire reset,
  // frequency difference from the phase detector
  input wire freqDiffValid,
  input wire [`LLMI_DIFF_WIDTH-1:0] freqDiffMag,
  // live input signal-loss alarms
  input wire [1:0] signalLossLive,
  // register port
  input wire [15:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWriteData,
  output wire [7:0] regReadData,
  // status pins
  output wire lockLostPin,
  output wire interruptPinN
);

  // ****************************************************************
  // threshold lookup
  // ****************************************************************
  // codes above the table saturate at the widest window
  function [`LLMI_DIFF_WIDTH-1:0] thrTenths;
    input [3:0] code;
    begin
      case (code)
        4'h0: thrTenths = 20'h00002;
        4'h1: thrTenths = 20'h00006;
        4'h2: thrTenths = 20'h00014;
        4'h3: thrTenths = 20'h0003c;
        4'h4: thrTenths = 20'h000c8;
        4'h5: thrTenths = 20'h00258;
        4'h6: thrTenths = 20'h007d0;
        4'h7: thrTenths = 20'h01770;
        4'h8: thrTenths = 20'h04e20;
        4'h9: thrTenths = 20'h0ea60;
        default: thrTenths = 20'h30d40;
      endcase
    end
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [3:0] assertThr_reg;
  reg [3:0] deassertThr_reg;
  reg timerEnable_reg;
  reg [34:0] clearDelay_reg;
  reg [1:0] signalLossMask_reg;
  reg lockMask_reg;
  reg [1:0] signalLossSticky_reg;
  reg lockSticky_reg;
  reg lockLost_reg;
  reg [1:0] state_reg;
  reg [34:0] timerCount_reg;
  reg interruptN_reg;
  reg [7:0] readData_reg;

  reg [1:0] state_next;
  reg lockLost_next;
  reg [34:0] timerCount_next;
  reg [7:0] readData_next;

  wire [`LLMI_DIFF_WIDTH-1:0] assertLimit;
  wire [`LLMI_DIFF_WIDTH-1:0] deassertLimit;
  wire assertHit;
  wire deassertHit;
  wire writeSignalSticky;
  wire writeLockSticky;
  wire [2:0] allSticky;
  wire [2:0] allMask;
  wire [2:0] allLive;

  // ****************************************************************
  // comparators
  // ****************************************************************
  assign assertLimit = thrTenths(assertThr_reg);
  assign deassertLimit = thrTenths(deassertThr_reg);
  // only a fresh measurement can move the monitor out of the locked or lost state
  assign assertHit = freqDiffValid && (freqDiffMag > assertLimit);
  assign deassertHit = freqDiffValid && (freqDiffMag < deassertLimit);

  // ****************************************************************
  // monitor state machine
  // ****************************************************************
  localparam [1:0] ST_LOCKED = 2'b00;
  localparam [1:0] ST_LOST = 2'b01;
  localparam [1:0] ST_HOLDOFF = 2'b10;

  always @*
  begin
    state_next = state_reg;
    lockLost_next = lockLost_reg;
    timerCount_next = timerCount_reg;
    case (state_reg)
      ST_LOCKED:
      begin
        if (assertHit)
        begin
          state_next = ST_LOST;
          lockLost_next = 1'b1;
        end
      end
      ST_LOST:
      begin
        if (deassertHit)
        begin
          if (timerEnable_reg && (clearDelay_reg != 35'h000000000))
          begin
            state_next = ST_HOLDOFF;
            timerCount_next = 35'h000000000;
          end
          else
          begin
            state_next = ST_LOCKED;
            lockLost_next = 1'b0;
          end
        end
      end
      ST_HOLDOFF:
      begin
        // a new excursion abandons the hold-off; the next clear
        // condition starts it again from zero
        if (assertHit)
        begin
          state_next = ST_LOST;
          timerCount_next = 35'h000000000;
        end
        else if (timerCount_reg >= clearDelay_reg - 35'h000000001)
        begin
          state_next = ST_LOCKED;
          lockLost_next = 1'b0;
        end
        else
        begin
          timerCount_next = timerCount_reg + 35'h000000001;
        end
      end
      default:
      begin
        state_next = ST_LOST;
        lockLost_next = 1'b1;
      end
    endcase
  end

  always @(posedge clock)
  begin
    if (reset)
    begin
      // start as lost: nothing is known about lock until measured
      state_reg <= ST_LOST;
      lockLost_reg <= 1'b1;
      timerCount_reg <= 35'h000000000;
    end
    else
    begin
      state_reg <= state_next;
      lockLost_reg <= lockLost_next;
      timerCount_reg <= timerCount_next;
    end
  end

  assign lockLostPin = lockLost_reg;

  // ****************************************************************
  // control registers
  // ****************************************************************
  always @(posedge clock)
  begin
    if (reset)
    begin
      assertThr_reg <= `LLMI_ASSERT_THR_RESET;
      deassertThr_reg <= `LLMI_DEASSERT_THR_RESET;
      timerEnable_reg <= `LLMI_TIMER_EN_RESET;
      clearDelay_reg <= `LLMI_DELAY_RESET;
      signalLossMask_reg <= `LLMI_SIGNAL_LOSS_MASK_RESET;
      lockMask_reg <= `LLMI_LOCK_MASK_RESET;
    end
    else if (regWrite)
    begin
      case (regAddr)
        `LLMI_ADDR_ASSERT_THR:
          assertThr_reg <= regWriteData[`LLMI_THR_MSB:`LLMI_THR_LSB];
        `LLMI_ADDR_DEASSERT_THR:
          deassertThr_reg <= regWriteData[`LLMI_THR_MSB:`LLMI_THR_LSB];
        `LLMI_ADDR_TIMER_EN:
          timerEnable_reg <= regWriteData[`LLMI_TIMER_EN_BIT];
        `LLMI_ADDR_DELAY_B0:
          clearDelay_reg[7:0] <= regWriteData;
        `LLMI_ADDR_DELAY_B1:
          clearDelay_reg[15:8] <= regWriteData;
        `LLMI_ADDR_DELAY_B2:
          clearDelay_reg[23:16] <= regWriteData;
        `LLMI_ADDR_DELAY_B3:
          clearDelay_reg[31:24] <= regWriteData;
        `LLMI_ADDR_DELAY_B4:
          clearDelay_reg[34:32] <= regWriteData[`LLMI_DELAY_TOP_BITS-1:0];
        `LLMI_ADDR_SIGNAL_LOSS_MASK:
          signalLossMask_reg <= regWriteData[1:0];
        `LLMI_ADDR_LOCK_MASK:
          lockMask_reg <= regWriteData[`LLMI_LOCK_BIT];
        default:
        begin
          assertThr_reg <= assertThr_reg;
        end
      endcase
    end
  end

  // ****************************************************************
  // sticky flags
  // ****************************************************************
  assign writeSignalSticky = regWrite &&
    (regAddr == `LLMI_ADDR_SIGNAL_LOSS_STICKY);
  assign writeLockSticky = regWrite && (regAddr == `LLMI_ADDR_LOCK_STICKY);

  assign allLive = {lockLost_reg, signalLossLive};
  assign allMask = {lockMask_reg, signalLossMask_reg};
  assign allSticky = {lockSticky_reg, signalLossSticky_reg};

  // a live alarm re-sets its flag every cycle, so a zero written while
  // the alarm is high has no lasting effect and the set always wins
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : gSignalSticky
      always @(posedge clock)
      begin
        if (reset)
          signalLossSticky_reg[i] <= 1'b0;
        else if (signalLossLive[i])
          signalLossSticky_reg[i] <= 1'b1;
        else if (writeSignalSticky && !regWriteData[i])
          signalLossSticky_reg[i] <= 1'b0;
      end
    end
  endgenerate

  always @(posedge clock)
  begin
    if (reset)
      lockSticky_reg <= 1'b0;
    else if (lockLost_reg)
      lockSticky_reg <= 1'b1;
    else if (writeLockSticky && !regWriteData[`LLMI_LOCK_BIT])
      lockSticky_reg <= 1'b0;
  end

  // ****************************************************************
  // interrupt pin
  // ****************************************************************
  // flags are set every cycle an alarm is high, so the pin reports any unmasked alarm raised since the last clear
  always @(posedge clock)
  begin
    if (reset)
      interruptN_reg <= 1'b1;
    else
      interruptN_reg <= ~|(allSticky & ~allMask);
  end

  assign interruptPinN = interruptN_reg;

  // ****************************************************************
  // read path
  // ****************************************************************
  // unmapped offsets and reserved bits read as zero
  always @*
  begin
    readData_next = 8'h00;
    case (regAddr)
      `LLMI_ADDR_SIGNAL_LOSS_LIVE:
        readData_next[1:0] = signalLossLive;
      `LLMI_ADDR_LOCK_LIVE:
        readData_next[`LLMI_LOCK_BIT] = lockLost_reg;
      `LLMI_ADDR_SIGNAL_LOSS_STICKY:
        readData_next[1:0] = signalLossSticky_reg;
      `LLMI_ADDR_LOCK_STICKY:
        readData_next[`LLMI_LOCK_BIT] = lockSticky_reg;
      `LLMI_ADDR_SIGNAL_LOSS_MASK:
        readData_next[1:0] = signalLossMask_reg;
      `LLMI_ADDR_LOCK_MASK:
        readData_next[`LLMI_LOCK_BIT] = lockMask_reg;
      `LLMI_ADDR_ASSERT_THR:
        readData_next[`LLMI_THR_MSB:`LLMI_THR_LSB] = assertThr_reg;
      `LLMI_ADDR_DEASSERT_THR:
        readData_next[`LLMI_THR_MSB:`LLMI_THR_LSB] = deassertThr_reg;
      `LLMI_ADDR_TIMER_EN:
        readData_next[`LLMI_TIMER_EN_BIT] = timerEnable_reg;
      `LLMI_ADDR_DELAY_B0:
        readData_next = clearDelay_reg[7:0];
      `LLMI_ADDR_DELAY_B1:
        readData_next = clearDelay_reg[15:8];
      `LLMI_ADDR_DELAY_B2:
        readData_next = clearDelay_reg[23:16];
      `LLMI_ADDR_DELAY_B3:
        readData_next = clearDelay_reg[31:24];
      `LLMI_ADDR_DELAY_B4:
        readData_next[2:0] = clearDelay_reg[34:32];
      default:
        readData_next = 8'h00;
    endcase
  end

  // read data holds until the next read strobe
  always @(posedge clock)
  begin
    if (reset)
      readData_reg <= 8'h00;
    else if (regRead)
      readData_reg <= readData_next;
  end

  assign regReadData = readData_reg;

endmodule

// *** tb/llmi_lock_monitor_chk.sv ***
// assertions on the lock monitor pins and register port
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`include "llmi_defs.vh"

module llmi_lock_monitor_chk
(
  // clock and reset
  input wire clock,
  input wire reset,
  // monitor and register inputs
  input wire freqDiffValid,
  input wire [`LLMI_DIFF_WIDTH-1:0] freqDiffMag,
  input wire [1:0] signalLossLive,
  input wire [15:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWriteData,
  // outputs
  input wire [7:0] regReadData,
  input wire lockLostPin,
  input wire interruptPinN
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // ****************************************************************
  // sequences
  // ****************************************************************
  sequence s_bigDiff;
    freqDiffValid && freqDiffMag > 20'h30d40;
  endsequence
  sequence s_stickyRead;
    lockLostPin ##1 (regRead && regAddr == `LLMI_ADDR_LOCK_STICKY);
  endsequence
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_setHigh;
    s_bigDiff |=> lockLostPin;
  endproperty
  property p_noMeas;
    !freqDiffValid && !lockLostPin |=> !lockLostPin;
  endproperty
  property p_liveRead;
    regRead && regAddr == `LLMI_ADDR_LOCK_LIVE
      |=> regReadData == {6'h00, $past(lockLostPin), 1'b0};
  endproperty
  property p_sticky;
    s_stickyRead |=> regReadData[1];
  endproperty
  property p_unmapped;
    regRead && regAddr == 16'h0001 |=> regReadData == 8'h00;
  endproperty
  property p_readHold;
    !regRead |=> $stable(regReadData);
  endproperty
  // interrupt can only fall two or three edges after a cause
  property p_intFall;
    $fell(interruptPinN) |-> $past(regWrite, 2) || $past(lockLostPin, 2)
      || $past(lockLostPin, 3) || $past(|signalLossLive, 2);
  endproperty
  property p_intRise;
    $rose(interruptPinN) |-> $past(regWrite, 2) || $past(reset);
  endproperty
  a_setHigh: assert property (p_setHigh) else $error("no lock loss");
  a_noMeas: assert property (p_noMeas) else $error("loss unmeasured");
  a_liveRead: assert property (p_liveRead) else $error("live bit");
  a_sticky: assert property (p_sticky) else $error("sticky lost");
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  a_readHold: assert property (p_readHold) else $error("read data moved");
  a_intFall: assert property (p_intFall) else $error("irq cause");
  a_intRise: assert property (p_intRise) else $error("irq clear");
endmodule

bind llmi_lock_monitor llmi_lock_monitor_chk u_chk (.clock(clock),
  .reset(reset), .freqDiffValid(freqDiffValid), .freqDiffMag(freqDiffMag),
  .signalLossLive(signalLossLive), .regAddr(regAddr), .regWrite(regWrite),
  .regRead(regRead), .regWriteData(regWriteData),
  .regReadData(regReadData), .lockLostPin(lockLostPin),
  .interruptPinN(interruptPinN));

// *** tb/llmi_lock_monitor_tb.sv ***
// self-checking bench for the lock monitor through its register port
// assumes inputs change 1 ns after each rising edge
`timescale 1ns/1ps
`include "llmi_defs.vh"

module llmi_lock_monitor_tb;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic freqDiffValid = 1'b0;
  logic [19:0] freqDiffMag = 20'h00000;
  logic [1:0] signalLossLive = 2'h0;
  logic [15:0] regAddr = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regWriteData = 8'h00;
  wire [7:0] regReadData;
  wire lockLostPin;
  wire interruptPinN;
  int error_cnt = 0;
  int tests_run = 0;
  // threshold steps in tenths of a ppm
  logic [19:0] lim [0:10] = '{20'h00002, 20'h00006, 20'h00014,
    20'h0003c, 20'h000c8, 20'h00258, 20'h007d0, 20'h01770,
    20'h04e20, 20'h0ea60, 20'h30d40};

  always #10 clock = ~clock;

  llmi_lock_monitor DUT (.clock(clock), .reset(reset),
    .freqDiffValid(freqDiffValid), .freqDiffMag(freqDiffMag),
    .signalLossLive(signalLossLive), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWriteData(regWriteData),
    .regReadData(regReadData), .lockLostPin(lockLostPin),
    .interruptPinN(interruptPinN));

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // each strobe is followed by one idle edge, so a following call never
  // raises a strobe in the same step in which this one lowered it
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    regAddr = a;
    regWriteData = d;
    regWrite = 1'b1;
    cyc(1);
    regWrite = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    regAddr = a;
    regRead = 1'b1;
    cyc(1);
    regRead = 1'b0;
    chk(regReadData, e);
    cyc(1);
  endtask
  task automatic meas(input logic [19:0] m);
    freqDiffMag = m;
    freqDiffValid = 1'b1;
    cyc(1);
    freqDiffValid = 1'b0;
    cyc(1);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    int n;
    logic [19:0] limit;
    cyc(8);
    reset = 1'b0;
    chk(lockLostPin, 1);
    chk(interruptPinN, 1);
    rd(`LLMI_ADDR_ASSERT_THR, 8'h00);
    rd(`LLMI_ADDR_DEASSERT_THR, 8'h20);
    rd(`LLMI_ADDR_TIMER_EN, 8'h00);
    rd(16'h0001, 8'h00);
    rd(`LLMI_ADDR_LOCK_MASK, 8'h02);
    rd(`LLMI_ADDR_LOCK_STICKY, 8'h02);
    $display("test reset done");
    meas(20'h00001);
    chk(lockLostPin, 0);
    rd(`LLMI_ADDR_LOCK_LIVE, 8'h00);
    rd(`LLMI_ADDR_LOCK_STICKY, 8'h02);
    wr(`LLMI_ADDR_LOCK_STICKY, 8'h00);
    rd(`LLMI_ADDR_LOCK_STICKY, 8'h00);
    $display("test lock done");
    wr(`LLMI_ADDR_LOCK_MASK, 8'h00);
    meas(20'h00003);
    chk(lockLostPin, 1);
    cyc(1);
    chk(interruptPinN, 0);
    rd(`LLMI_ADDR_LOCK_LIVE, 8'h02);
    wr(`LLMI_ADDR_LOCK_STICKY, 8'h00);
    rd(`LLMI_ADDR_LOCK_STICKY, 8'h02);
    // a difference equal to the deassert limit does not clear
    meas(20'h00014);
    chk(lockLostPin, 1);
    meas(20'h00013);
    chk(lockLostPin, 0);
    chk(interruptPinN, 0);
    wr(`LLMI_ADDR_LOCK_STICKY, 8'h00);
    cyc(1);
    chk(interruptPinN, 1);
    wr(`LLMI_ADDR_LOCK_MASK, 8'h02);
    meas(20'h00003);
    cyc(3);
    chk(interruptPinN, 1);
    $display("test interrupt done");
    // codes past the table behave as the widest step
    for (int c = 0; c < 16; c++)
    begin
      limit = lim[(c > 10) ? 10 : c];
      wr(`LLMI_ADDR_ASSERT_THR, {c[3:0], 4'h0});
      wr(`LLMI_ADDR_DEASSERT_THR, {c[3:0], 4'h0});
      meas(20'h00000);
      chk(lockLostPin, 0);
      meas(limit);
      chk(lockLostPin, 0);
      meas(limit + 20'h00001);
      chk(lockLostPin, 1);
      meas(limit);
      chk(lockLostPin, 1);
      meas(limit - 20'h00001);
      chk(lockLostPin, 0);
    end
    wr(`LLMI_ADDR_ASSERT_THR, 8'h00);
    wr(`LLMI_ADDR_DEASSERT_THR, 8'h20);
    $display("test thresholds done");
    wr(`LLMI_ADDR_DELAY_B0, 8'h05);
    wr(`LLMI_ADDR_DELAY_B4, 8'hff);
    rd(`LLMI_ADDR_DELAY_B4, 8'h07);
    wr(`LLMI_ADDR_DELAY_B4, 8'h00);
    wr(`LLMI_ADDR_TIMER_EN, 8'h02);
    rd(`LLMI_ADDR_TIMER_EN, 8'h02);
    meas(20'h00003);
    meas(20'h00000);
    cyc(1);
    meas(20'h00003);
    meas(20'h00000);
    cyc(3);
    chk(lockLostPin, 1);
    n = 0;
    while (lockLostPin !== 1'b0 && n < 20)
    begin
      cyc(1);
      n++;
    end
    // a hang is counted here and again by the checks below, and the run still reaches the verdict
    if (n == 20)
      error_cnt++;
    chk(n[7:0], 8'h01);
    chk(lockLostPin, 0);
    wr(`LLMI_ADDR_TIMER_EN, 8'h00);
    $display("test delay done");
    signalLossLive = 2'h1;
    cyc(3);
    rd(`LLMI_ADDR_SIGNAL_LOSS_LIVE, 8'h01);
    rd(`LLMI_ADDR_SIGNAL_LOSS_STICKY, 8'h01);
    chk(interruptPinN, 1);
    wr(`LLMI_ADDR_SIGNAL_LOSS_MASK, 8'h02);
    cyc(1);
    chk(interruptPinN, 0);
    rd(`LLMI_ADDR_SIGNAL_LOSS_STICKY, 8'h01);
    wr(`LLMI_ADDR_SIGNAL_LOSS_STICKY, 8'h00);
    rd(`LLMI_ADDR_SIGNAL_LOSS_STICKY, 8'h01);
    signalLossLive = 2'h0;
    wr(`LLMI_ADDR_SIGNAL_LOSS_STICKY, 8'h00);
    cyc(1);
    chk(interruptPinN, 1);
    $display("test signal loss done");
    print_verdict();
  end
endmodule
